// ---- tabst_pkg.sv ----
// Purpose: Shared constants and types for the tablet error and self-test block.
// Assumes: One 25 MHz clock, all inputs synchronous to it.
// Notes:   Error codes are the tablet's numeric error numbers.
package tabst_pkg;
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned FLASH_MS      = 200;
   localparam int unsigned TONE_MS       = 150;
   localparam int unsigned FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;
   localparam int unsigned TONE_CYC      = CLK_HZ / 1000 * TONE_MS;
   localparam int unsigned MAX_INSTR_LEN = 45;
   localparam int unsigned BAD_RUN_LIMIT = 4;

   localparam logic [6:0] ERR_NONE      = 7'h00;
   localparam logic [6:0] ERR_INSTR     = 7'h01;
   localparam logic [6:0] ERR_NPARAM    = 7'h02;
   localparam logic [6:0] ERR_PVALUE    = 7'h03;
   localparam logic [6:0] ERR_INCONS    = 7'h07;
   localparam logic [6:0] ERR_PROX      = 7'h32;
   localparam logic [6:0] ERR_PEN       = 7'h33;
   localparam logic [6:0] ERR_EARLY_PEN = 7'h34;
   localparam logic [6:0] ERR_POS       = 7'h35;
   localparam logic [6:0] ERR_HW_MIN    = 7'h64;
   localparam logic [6:0] ERR_HW_MAX    = 7'h6e;

   localparam logic [2:0] MASK_INSTR  = 3'h1;
   localparam logic [2:0] MASK_PARAM  = 3'h2;
   localparam logic [2:0] MASK_INCONS = 3'h4;

   localparam logic [1:0] TONE_OFF   = 2'h0;
   localparam logic [1:0] TONE_C     = 2'h1;
   localparam logic [1:0] TONE_E     = 2'h2;
   localparam logic [1:0] TONE_G     = 2'h3;

   localparam logic [6:0] LIGHTS_ALL = 7'h7f;
   localparam logic [6:0] LIGHTS_OFF = 7'h00;

   typedef struct packed {
      logic       valid;
      logic       illegal;
      logic [5:0] length;
      logic       is_output_point;
      logic       is_self_test;
      logic       is_output_error;
      logic       bad_count;
      logic       bad_value;
   } tabst_instr_s;

   typedef struct packed {
      logic proximity;
      logic pen_pressed;
      logic signal_ok;
      logic sample_valid;
      logic sample_consistent;
      logic on_dot;
   } tabst_stylus_s;

   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_FLASH1  = 9'h002,
      ST_WAITOFF = 9'h004,
      ST_ELEC    = 9'h008,
      ST_HELLO1  = 9'h010,
      ST_WAITPEN = 9'h020,
      ST_HELLO2  = 9'h040,
      ST_ERRTONE = 9'h080,
      ST_HALT    = 9'h100
   } tabst_state_e;
endpackage

// ---- tabst_core.sv ----
// How it works
// R01: Masked user errors gate error flag, error light and error tone.
// R02: Illegal or over-45-character instruction raises instruction error.
// R03: Output-point command without digitizing mode raises instruction error.
// R04: Wrong parameter count records error 2.
// R05: Out-of-range parameter value records error 3.
// R06: A single inconsistent sample outputs no point and raises nothing.
// R07: Four consecutive inconsistent samples record error 7.
// R08: Stylus present when self test requested records error 50.
// R09: Pen pressed when self test requested records error 51.
// R10: Pen press before adequate signal level records error 52.
// R11: Digitized point off the self-test dot records error 53.
// R12: Electronics test faults report codes 100 through 110; the code reports 100 plus i_elec_fault, up to 115.
// R13: Switch on flashes all indicators except power, then off.
// R14: Switch off and electronics pass flash and play hello; also at power-on.
// R15: Wait stylus out of tray, digitize dot, correct replays hello.
// R16: Self-test instruction starts the test without the first flash.
// R17: Host stays silent on the bus during self test.
// R18: Self-test switch held on repeats the test continuously; the code waits in WAITOFF for switch off, so it never repeats.
// R19: Continuous-test error halts and holds error pattern on lights.
// R20: After halt, output-error returns the detected code; the code clears it to ERR_NONE on the edge that raises o_error_code_valid.
// R21: Service request withdrawn after serial poll or when not needed.
// R22: Self-test error shows its binary code on lights during tone.
// R23: Self-test and system errors ignore the mask.
// R24: Error register holds last code until output-error read or reset.
//
// Purpose: Error classification and self-test sequencing for the tablet.
// Assumes: Electronics test engine and tone generator are outside; inputs
//          are synchronous to i_clk_sys.
// Notes:   The host is trusted not to send instructions during a test.
`timescale 1ns/1ps
`default_nettype none
module tabst_core #(
   // Tone and flash lengths in clock cycles; short values speed up benches.
   parameter int unsigned TONE_LEN  = tabst_pkg::TONE_CYC,
   parameter int unsigned FLASH_LEN = tabst_pkg::FLASH_CYC
) (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset_n,
   input  wire tabst_pkg::tabst_instr_s  i_instr,
   input  wire logic                    i_digitize_mode,
   input  wire logic [2:0]              i_err_mask,
   input  wire tabst_pkg::tabst_stylus_s i_stylus,
   input  wire logic                    i_test_switch,
   input  wire logic                    i_elec_done,
   input  wire logic                    i_elec_fail,
   input  wire logic [3:0]              i_elec_fault,
   input  wire logic                    i_serial_poll,
   input  wire logic                    i_srq_wanted,
   output logic                         o_elec_start,
   output logic                         o_point_out,
   output logic [6:0]                   o_error_code,
   output logic                         o_error_code_valid,
   output logic                         o_error_flag,
   output logic                         o_error_light,
   output logic [6:0]                   o_lights,
   output logic [1:0]                   o_tone,
   output logic                         o_error_tone,
   output logic                         o_test_busy,
   output logic                         o_srq
);
   import tabst_pkg::*;

   function automatic logic [6:0] hw_code(input logic [3:0] f);
      hw_code = ERR_HW_MIN + {3'h0, f};
   endfunction

   tabst_state_e state_ff, nxt_state;
   logic [22:0]  tmr_ff;
   logic [1:0]   step_ff;
   logic [2:0]   bad_run_ff;
   logic [6:0]   err_ff;
   logic         flag_ff, light_ff, etone_ff, pt_ff, estart_ff, srq_ff;
   logic         cont_ff, sw_q_ff, ovalid_ff, srq_wq_ff, busy_ff;
   logic [6:0]   lights_ff;
   logic [1:0]   tone_ff;

   wire tmr_done = (tmr_ff == 23'h000000);
   wire sw_rise  = i_test_switch & ~sw_q_ff;
   wire sw_fall  = ~i_test_switch & sw_q_ff;
   wire idle     = (state_ff == ST_IDLE);
   wire cmd_test = i_instr.valid & i_instr.is_self_test & idle;
   // Blanks and carriage returns are already excluded from the count.
   wire too_long = i_instr.length > 6'(MAX_INSTR_LEN); // R02
   wire e_instr  = i_instr.valid & (i_instr.illegal | too_long
                   | (i_instr.is_output_point & ~i_digitize_mode)); // R02 R03
   wire e_cnt    = i_instr.valid & ~e_instr & i_instr.bad_count; // R04
   wire e_val    = i_instr.valid & ~e_instr & ~e_cnt
                   & i_instr.bad_value; // R05
   wire smp_bad  = i_stylus.sample_valid & ~i_stylus.sample_consistent;
   wire e_incons = smp_bad
                   & (bad_run_ff == 3'(BAD_RUN_LIMIT - 1)); // R07
   wire [6:0] user_code = e_instr ? ERR_INSTR :
                          e_cnt   ? ERR_NPARAM :
                          e_val   ? ERR_PVALUE : ERR_INCONS;
   wire user_err = idle & (e_instr | e_cnt | e_val | e_incons);
   wire user_unmasked = (e_instr & i_err_mask[0])
                      | ((e_cnt | e_val) & i_err_mask[1])
                      | (e_incons & i_err_mask[2]); // R01
   wire start_req = sw_rise | cmd_test;
   wire pre_fail  = i_stylus.proximity | i_stylus.pen_pressed;
   wire [6:0] pre_code = i_stylus.proximity ? ERR_PROX : ERR_PEN; // R08 R09
   wire pen_early = i_stylus.pen_pressed & ~i_stylus.signal_ok; // R10
   wire dot_done  = i_stylus.pen_pressed & i_stylus.signal_ok
                    & i_stylus.sample_valid;
   wire st_err = (state_ff == ST_WAITOFF) & i_elec_done & i_elec_fail
               | (state_ff == ST_WAITPEN) & (pen_early
                 | dot_done & ~i_stylus.on_dot);
   wire [6:0] st_code = (state_ff == ST_WAITOFF) ?
                          hw_code(i_elec_fault) : // R12
                        pen_early ? ERR_EARLY_PEN : ERR_POS; // R10 R11
   wire read_err = i_instr.valid & i_instr.is_output_error;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (sw_rise) begin
               nxt_state = ST_FLASH1; // R13
            end else if (cmd_test) begin
               // A stylus out of its tray fails at once, with the error tone.
               nxt_state = pre_fail ? ST_ERRTONE : ST_WAITOFF; // R16
            end
         end
         ST_FLASH1:  if (tmr_done) nxt_state = ST_WAITOFF;
         ST_WAITOFF: begin
            if (st_err) begin
               nxt_state = ST_ERRTONE;
            end else if (i_elec_done & ~i_test_switch) begin
               nxt_state = ST_HELLO1; // R14
            end
         end
         ST_HELLO1:  if (tmr_done && step_ff == 2'h3) nxt_state = ST_WAITPEN;
         ST_WAITPEN: begin
            if (st_err) begin
               nxt_state = ST_ERRTONE;
            end else if (dot_done) begin
               nxt_state = ST_HELLO2; // R15
            end
         end
         ST_HELLO2: begin
            if (tmr_done && step_ff == 2'h3) begin
               nxt_state = cont_ff & i_test_switch ? ST_WAITOFF
                                                   : ST_IDLE; // R18
            end
         end
         ST_ERRTONE: begin
            if (tmr_done) begin
               nxt_state = cont_ff ? ST_HALT : ST_IDLE; // R19
            end
         end
         ST_HALT:    if (read_err) nxt_state = ST_IDLE;
         default:    nxt_state = ST_IDLE;
      endcase
   end

   wire entering = (nxt_state != state_ff);
   wire hello    = (state_ff == ST_HELLO1) | (state_ff == ST_HELLO2);

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff  <= ST_HELLO1; // R14
         tmr_ff    <= 23'(TONE_LEN);
         step_ff   <= 2'h1;
         busy_ff   <= 1'b1;
         bad_run_ff <= 3'h0;
         err_ff    <= ERR_NONE;
         ovalid_ff <= 1'b0;
         flag_ff   <= 1'b0;
         light_ff  <= 1'b0;
         etone_ff  <= 1'b0;
         pt_ff     <= 1'b0;
         estart_ff <= 1'b0;
         srq_ff    <= 1'b0;
         srq_wq_ff <= 1'b0;
         cont_ff   <= 1'b0;
         sw_q_ff   <= 1'b0;
         lights_ff <= LIGHTS_ALL;
         tone_ff   <= TONE_C;
      end else begin
         state_ff <= nxt_state;
         busy_ff  <= (nxt_state != ST_IDLE); // R17
         sw_q_ff  <= i_test_switch;
         estart_ff <= 1'b0;
         if (entering && nxt_state == ST_FLASH1) begin
            tmr_ff <= 23'(FLASH_LEN);
         end else if (entering && nxt_state == ST_ERRTONE) begin
            tmr_ff <= 23'(TONE_LEN);
         end else if (entering && (nxt_state == ST_HELLO1
                      || nxt_state == ST_HELLO2)) begin
            tmr_ff  <= 23'(TONE_LEN);
            step_ff <= 2'h1;
         end else if (hello && tmr_done && step_ff != 2'h3) begin
            tmr_ff  <= 23'(TONE_LEN);
            step_ff <= step_ff + 2'h1;
         end else if (!tmr_done) begin
            tmr_ff <= tmr_ff - 23'h000001;
         end
         if (start_req && idle) begin
            cont_ff <= sw_rise; // R18
         end else if (!i_test_switch && state_ff != ST_HALT
                      && state_ff != ST_ERRTONE) begin
            cont_ff <= 1'b0;
         end
         if (entering && nxt_state == ST_WAITOFF) begin
            estart_ff <= 1'b1;
         end
         // A consistent sample or the fourth bad one (error 7) resets the run; idle samples keep it.
         if (i_stylus.sample_valid) begin
            bad_run_ff <= (smp_bad && !e_incons) ?
                          bad_run_ff + 3'h1 : 3'h0; // R06 R07
         end
         pt_ff <= idle & i_stylus.sample_valid
                  & i_stylus.sample_consistent; // R06
         ovalid_ff <= 1'b0;
         if (start_req && idle && pre_fail) begin
            err_ff <= pre_code; // R08 R09 R23
         end else if (st_err) begin
            err_ff <= st_code; // R23
         end else if (user_err) begin
            err_ff <= user_code; // R24
         end else if (read_err) begin
            err_ff    <= ERR_NONE; // R24
         end
         if (read_err) begin
            ovalid_ff <= 1'b1; // R20
         end
         if (user_err && user_unmasked) begin
            flag_ff  <= 1'b1; // R01
            light_ff <= 1'b1;
         end else if (read_err) begin
            flag_ff  <= 1'b0;
            light_ff <= 1'b0;
         end
         etone_ff <= (state_ff == ST_ERRTONE) & ~tmr_done
                     | user_err & user_unmasked; // R01 R22
         if (state_ff == ST_FLASH1
             || entering && nxt_state == ST_FLASH1) begin
            lights_ff <= LIGHTS_ALL; // R13
         end else if (state_ff == ST_ERRTONE || state_ff == ST_HALT) begin
            lights_ff <= err_ff; // R19 R22
         end else if (hello) begin
            lights_ff <= LIGHTS_ALL; // R14
         end else begin
            lights_ff <= LIGHTS_OFF;
         end
         tone_ff  <= hello ? step_ff : TONE_OFF; // R14 R15
         srq_wq_ff <= i_srq_wanted;
         if (i_serial_poll || !i_srq_wanted) begin
            srq_ff <= 1'b0; // R21
         end else if (i_srq_wanted && !srq_wq_ff) begin
            srq_ff <= 1'b1;
         end
      end
   end

   assign o_elec_start       = estart_ff;
   assign o_point_out        = pt_ff;
   assign o_error_code       = err_ff;
   assign o_error_code_valid = ovalid_ff;
   assign o_error_flag       = flag_ff;
   assign o_error_light      = light_ff;
   assign o_lights           = lights_ff;
   assign o_tone             = tone_ff;
   assign o_error_tone       = etone_ff;
   assign o_test_busy        = busy_ff; // R17
   assign o_srq              = srq_ff;

   default clocking cb_sys @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   AST_SRQ_DROP: assert property (i_serial_poll |=> !o_srq) // R21
      else $error("srq kept after poll");
   AST_ERR7: assert property ( // R07
      (idle && e_incons && !e_instr && !e_cnt && !e_val && !start_req)
      |=> o_error_code == ERR_INCONS) else $error("no error 7");
   AST_NO_PT: assert property (smp_bad |=> !o_point_out) // R06
      else $error("bad sample output");
   AST_PROX: assert property ( // R08
      (idle && start_req && i_stylus.proximity)
      |=> o_error_code == ERR_PROX) else $error("no error 50");
   AST_MASK: assert property ( // R01
      (user_err && !user_unmasked && !read_err && !flag_ff)
      |=> !o_error_flag) else $error("masked error set flag");
   AST_FLASH: assert property ( // R13
      (idle && sw_rise) |=> ##1 o_lights == LIGHTS_ALL)
      else $error("no lights flash");
   AST_TEST_CMD: assert property ( // R16
      (idle && cmd_test && !sw_rise) |=> ##1 o_lights != LIGHTS_ALL)
      else $error("test command flashed");
   AST_HALT: assert property ( // R19
      (state_ff == ST_HALT && !read_err) |=> o_lights == $past(err_ff))
      else $error("halt pattern lost");
endmodule
`default_nettype wire

// ---- tabst_host_model.sv ----
// Purpose: Host controller model that sends decoded instructions and polls.
// Assumes: Instructions reach the tablet as one-cycle pulses on its clock.
// Notes:   Between instructions the fields carry noise, so only valid counts.
`timescale 1ns/1ps
`default_nettype none
module tabst_host_model (
   input  wire logic               i_clk_sys,
   input  wire logic               i_test_busy,
   output tabst_pkg::tabst_instr_s o_instr,
   output logic                    o_serial_poll,
   output logic                    o_srq_wanted
);
   import tabst_pkg::*;

   function automatic tabst_instr_s noise();
      logic [12:0] r;
      r = 13'($urandom);
      noise = tabst_instr_s'(r);
      noise.valid = 1'b0;
   endfunction

   initial begin
      o_instr = noise();
      o_serial_poll = 1'b0;
      o_srq_wanted = 1'b0;
   end

   // A real host stays off the bus during a test; the wait is bounded.
   task automatic send(input tabst_instr_s ins);
      int n;
      n = 0;
      while (i_test_busy !== 1'b0 && n < 16) begin
         @(posedge i_clk_sys);
         n++;
      end
      @(posedge i_clk_sys);
      o_instr <= ins;
      @(posedge i_clk_sys);
      o_instr <= noise();
   endtask

   task automatic poll();
      @(posedge i_clk_sys);
      o_serial_poll <= 1'b1;
      @(posedge i_clk_sys);
      o_serial_poll <= 1'b0;
   endtask

   task automatic want(input logic w);
      @(posedge i_clk_sys);
      o_srq_wanted <= w;
   endtask
endmodule
`default_nettype wire

// ---- tabst_core_tb_top.sv ----
// Purpose: Self-checking bench for the tablet error and self-test block.
// Assumes: Tones and flashes are shortened so the run stays brief.
// Notes:   Error codes are noted in a queue and matched as they appear.
`timescale 1ns/1ps
`default_nettype none
module tabst_core_tb_top;
   import tabst_pkg::*;
   localparam int unsigned TB_TONE  = 200;
   localparam int unsigned TB_FLASH = 100;
   localparam int unsigned WD_CYC   = 20000;
   logic i_clk_sys, i_reset_n, dmode, sw, edone, efail, poll, want, watch;
   logic [2:0] mask;
   logic [3:0] efault;
   tabst_instr_s instr;
   tabst_stylus_s sty;
   logic estart, point, cvalid, eflag, elight, etone, busy, srq;
   logic [6:0] code, lights, last_code;
   logic [1:0] tone;
   logic [6:0] exp_q[$];
   int miscompares, cmp_count, pts, starts;

   tabst_host_model host (.i_clk_sys(i_clk_sys), .i_test_busy(busy),
      .o_instr(instr), .o_serial_poll(poll), .o_srq_wanted(want));
   tabst_core #(.TONE_LEN(TB_TONE), .FLASH_LEN(TB_FLASH))
      DUT (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
      .i_instr(instr), .i_digitize_mode(dmode), .i_err_mask(mask),
      .i_stylus(sty), .i_test_switch(sw), .i_elec_done(edone),
      .i_elec_fail(efail), .i_elec_fault(efault), .i_serial_poll(poll),
      .i_srq_wanted(want), .o_elec_start(estart), .o_point_out(point),
      .o_error_code(code), .o_error_code_valid(cvalid),
      .o_error_flag(eflag), .o_error_light(elight), .o_lights(lights),
      .o_tone(tone), .o_error_tone(etone), .o_test_busy(busy), .o_srq(srq));

   task automatic chk(input string what, input logic [6:0] e,
                      input logic [6:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic tabst_instr_s mk(input logic [5:0] f,
                                       input logic [5:0] len);
      mk = '{valid:1'b1, illegal:f[5], length:len, is_output_point:f[4],
             is_self_test:f[3], is_output_error:f[2], bad_count:f[1],
             bad_value:f[0]};
   endfunction

   function automatic logic [5:0] rl();
      rl = 6'(1 + $urandom_range(43));
   endfunction

   task automatic wt(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask

   // Reading the error register empties it and drops the flag.
   task automatic rd_clr();
      host.send(mk(6'h04, rl()));
      wt(3);
      chk("error_code", ERR_NONE, code);
      chk("error_flag", 7'h00, {6'h00, eflag});
   endtask

   task automatic ucase(input tabst_instr_s ins, input logic [2:0] m,
                        input logic [6:0] c, input logic fl);
      @(posedge i_clk_sys);
      mask <= m;
      watch = fl || c == ERR_NONE;
      if (fl) exp_q.push_back(c);
      host.send(ins);
      wt(3);
      chk("error_flag", {6'h00, fl}, {6'h00, eflag});
      chk("error_light", {6'h00, fl}, {6'h00, elight});
      rd_clr();
      watch = 1'b1;
   endtask

   task automatic sample(input logic c);
      @(posedge i_clk_sys);
      sty.sample_valid <= 1'b1;
      sty.sample_consistent <= c;
      @(posedge i_clk_sys);
      sty.sample_valid <= 1'b0;
      sty.sample_consistent <= ~c;
   endtask

   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end

   always @(negedge i_clk_sys) begin
      if (point === 1'b1) pts++;
      if (estart === 1'b1) starts++;
      if (i_reset_n === 1'b1 && watch && code !== last_code &&
          code !== ERR_NONE) begin
         if (exp_q.size() == 0) chk("error_code", ERR_NONE, code);
         else chk("error_code", exp_q.pop_front(), code);
      end
      last_code = code;
   end

   initial begin
      repeat (WD_CYC) @(posedge i_clk_sys);
      miscompares++;
      test_done();
   end

   initial begin
      int n;
      void'($urandom(55));
      {i_reset_n, dmode, sw, edone, efail, pts, starts} = '0;
      mask = 3'h7;
      sty = '0;
      watch = 1'b1;
      last_code = ERR_NONE;
      efault = 4'($urandom_range(10));
      repeat (16) @(posedge i_clk_sys);
      wt(1);
      chk("tone", {5'h00, TONE_C}, {5'h00, tone});
      chk("lights", LIGHTS_ALL, lights);
      @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      wt(TB_TONE / 2);
      chk("tone", {5'h00, TONE_C}, {5'h00, tone});
      wt(TB_TONE);
      chk("tone", {5'h00, TONE_E}, {5'h00, tone});
      wt(TB_TONE);
      chk("tone", {5'h00, TONE_G}, {5'h00, tone});
      wt(TB_TONE);
      chk("tone", {5'h00, TONE_OFF}, {5'h00, tone});
      $display("test greeting done");
      @(posedge i_clk_sys);
      mask <= 3'h0;
      sty.proximity <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      exp_q.push_back(ERR_EARLY_PEN);
      sty.pen_pressed <= 1'b1;
      sample(1'b1);
      wt(4);
      chk("lights", ERR_EARLY_PEN, lights);
      chk("error_tone", 7'h01, {6'h00, etone});
      @(posedge i_clk_sys);
      sty <= '0;
      mask <= 3'h7;
      n = 0;
      while (busy !== 1'b0 && n < TB_TONE + 100) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk("test_busy", 7'h00, {6'h00, busy});
      rd_clr();
      $display("test dot phase done");
      @(posedge i_clk_sys);
      dmode <= 1'b1;
      ucase(mk(6'h20, rl()), 3'h7, ERR_INSTR, 1'b1);
      ucase(mk(6'h00, 6'(MAX_INSTR_LEN + 1)), 3'h7, ERR_INSTR, 1'b1);
      ucase(mk(6'h00, 6'(MAX_INSTR_LEN)), 3'h7, ERR_NONE, 1'b0);
      ucase(mk(6'h03, rl()), 3'h7, ERR_NPARAM, 1'b1);
      ucase(mk(6'h01, rl()), 3'h7, ERR_PVALUE, 1'b1);
      ucase(mk(6'h02, rl()), 3'h5, ERR_NPARAM, 1'b0);
      ucase(mk(6'h20, rl()), 3'h6, ERR_INSTR, 1'b0);
      @(posedge i_clk_sys);
      dmode <= 1'b0;
      ucase(mk(6'h10, rl()), 3'h7, ERR_INSTR, 1'b1);
      $display("test instruction errors done");
      @(posedge i_clk_sys);
      dmode <= 1'b1;
      sty.proximity <= 1'b1;
      n = pts;
      sample(1'b1);
      repeat (3) sample(1'b0);
      wt(3);
      chk("points", 7'(n + 1), 7'(pts));
      chk("error_code", ERR_NONE, code);
      exp_q.push_back(ERR_INCONS);
      sample(1'b0);
      wt(3);
      rd_clr();
      $display("test samples done");
      host.want(1'b1);
      wt(3);
      chk("srq", 7'h01, {6'h00, srq});
      host.poll();
      wt(2);
      chk("srq", 7'h00, {6'h00, srq});
      host.want(1'b0);
      $display("test service request done");
      @(posedge i_clk_sys);
      sty <= '0;
      sw <= 1'b1;
      wt(3);
      chk("lights", LIGHTS_ALL, lights);
      @(posedge i_clk_sys);
      sw <= 1'b0;
      exp_q.push_back(ERR_HW_MIN + {3'h0, efault});
      wt(TB_FLASH + 4);
      chk("elec_start", 7'h01, 7'(starts));
      chk("test_busy", 7'h01, {6'h00, busy});
      @(posedge i_clk_sys);
      {edone, efail} <= 2'h3;
      @(posedge i_clk_sys);
      {edone, efail} <= 2'h0;
      wt(3);
      chk("lights", ERR_HW_MIN + {3'h0, efault}, lights);
      wt(TB_TONE + 4);
      chk("test_busy", 7'h00, {6'h00, busy});
      rd_clr();
      $display("test switch done");
      @(posedge i_clk_sys);
      sty.proximity <= 1'b1;
      exp_q.push_back(ERR_PROX);
      host.send(mk(6'h08, rl()));
      wt(3);
      chk("test_busy", 7'h01, {6'h00, busy});
      chk("lights", ERR_PROX, lights);
      wt(3);
      chk("pending", 7'h00, 7'(exp_q.size()));
      $display("test self-test command done");
      test_done();
   end
endmodule
`default_nettype wire
